// >>> pebank_pkg.sv
/*
 * Constants, register map and state layout of the event interrupt bank.
 * Assumes a 200 MHz logic clock and a synchronous register port.
 */
`default_nettype none

package pebank_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int PEB_CLK_PERIOD_NS = 5;
	localparam int PEB_MS_NS         = 1000000;
	localparam int PEB_MS_CYCLES     = PEB_MS_NS / PEB_CLK_PERIOD_NS;
	localparam int PEB_DIV_W         = 18;
	localparam int PEB_HOLD_W        = 14;
	localparam logic [PEB_HOLD_W-1:0] PEB_HOLD1_MS = 14'h03E8;
	localparam logic [PEB_HOLD_W-1:0] PEB_HOLD2_MS = 14'h07D0;
	localparam logic [PEB_HOLD_W-1:0] PEB_HOLD3_MS = 14'h0BB8;
	localparam logic [PEB_HOLD_W-1:0] PEB_HOLD4_MS = 14'h0FA0;
	localparam logic [PEB_HOLD_W-1:0] PEB_HOLD8_MS = 14'h1F40;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] PEB_ADDR_CATEGORY   = 8'h06;
	localparam logic [7:0] PEB_ADDR_REG_STAT   = 8'h18;
	localparam logic [7:0] PEB_ADDR_REG_MASK   = 8'h19;
	localparam logic [7:0] PEB_ADDR_REG_SENSE  = 8'h1A;
	localparam logic [7:0] PEB_ADDR_TEMP_STAT  = 8'h20;
	localparam logic [7:0] PEB_ADDR_TEMP_MASK  = 8'h21;
	localparam logic [7:0] PEB_ADDR_TEMP_SENSE = 8'h22;
	localparam logic [7:0] PEB_ADDR_BTN_STAT   = 8'h24;
	localparam logic [7:0] PEB_ADDR_BTN_MASK   = 8'h25;
	localparam logic [7:0] PEB_ADDR_BTN_SENSE  = 8'h26;
	localparam logic [7:0] PEB_ADDR_MISC_STAT  = 8'h28;
	localparam logic [7:0] PEB_ADDR_MISC_MASK  = 8'h29;

	// Group order: regulator, temperature, button, miscellaneous
	localparam int PEB_GROUPS = 4;
	localparam int PEB_G_REG  = 0;
	localparam int PEB_G_TEMP = 1;
	localparam int PEB_G_BTN  = 2;
	localparam int PEB_G_MISC = 3;
	localparam logic [PEB_GROUPS-1:0][7:0] PEB_STAT_ADDR =
		{PEB_ADDR_MISC_STAT, PEB_ADDR_BTN_STAT, PEB_ADDR_TEMP_STAT, PEB_ADDR_REG_STAT};
	localparam logic [PEB_GROUPS-1:0][7:0] PEB_MASK_ADDR =
		{PEB_ADDR_MISC_MASK, PEB_ADDR_BTN_MASK, PEB_ADDR_TEMP_MASK, PEB_ADDR_REG_MASK};
	localparam logic [PEB_GROUPS-1:0][7:0] PEB_VALID_BITS =
		{8'h1F, 8'h3F, 8'h05, 8'h07};
	localparam logic [7:0] PEB_STAT_RESET = 8'h00;

	// Category bit positions
	localparam int PEB_CAT_REG  = 4;
	localparam int PEB_CAT_BTN  = 5;
	localparam int PEB_CAT_TEMP = 6;
	localparam int PEB_CAT_MISC = 7;

	// Field positions
	localparam int PEB_TEMP_LOW  = 0;
	localparam int PEB_TEMP_HIGH = 2;
	localparam int PEB_MISC_WAKE = 0;
	localparam int PEB_MISC_DOZE = 1;
	localparam int PEB_MISC_PBTN = 2;
	localparam int PEB_MISC_LOW  = 3;
	localparam int PEB_MISC_OVER = 4;

	// ------------------------------------------------------------
	// State of the bank
	// ------------------------------------------------------------
	typedef struct packed {
		logic [PEB_GROUPS-1:0][7:0] stat;
		logic [PEB_GROUPS-1:0][7:0] mask;
		logic [1:0]                 temp_prev;
		logic [1:0]                 supply_prev;
		logic                       btn_live;
		logic [4:0]                 hold_live;
		logic [7:0]                 deb_cnt;
		logic [PEB_DIV_W-1:0]       ms_div;
		logic [PEB_HOLD_W-1:0]      hold_ms;
		logic [7:0]                 rdata;
		logic                       rvalid;
		logic                       irq_n;
	} pebank_state_s;

endpackage : pebank_pkg

`default_nettype wire

// >>> pebank_top.sv
/*
 * Event interrupt bank: status and mask groups, with sense for all but the last, for regulator
 * faults, die temperature, power button and miscellaneous events.
 * Assumes all inputs synchronous to I_CLK and a simple register port.
 */
`timescale 1ns/100ps
`default_nettype none

module pebank_top
	import pebank_pkg::*;
#(
	parameter int MS_CYCLES = PEB_MS_CYCLES
) (
	// Clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_RST_N,
	// Register port
	input  wire logic       I_REG_WR,
	input  wire logic       I_REG_RD,
	input  wire logic [7:0] I_REG_ADDR,
	input  wire logic [7:0] I_REG_WDATA,
	output var  logic [7:0] O_REG_RDATA,
	output var  logic       O_REG_RVALID,
	// Event sources
	input  wire logic [2:0] I_REG_FAULT,
	input  wire logic       I_TEMP_LOW_ABOVE,
	input  wire logic       I_TEMP_HIGH_ABOVE,
	input  wire logic       I_POWER_BUTTON_N,
	input  wire logic [7:0] I_DEB_PRESS_MS,
	input  wire logic [7:0] I_DEB_RELEASE_MS,
	input  wire logic       I_WAKE_DONE,
	input  wire logic       I_DOZE_DONE,
	input  wire logic       I_POWER_BUTTON_EVT,
	input  wire logic       I_SUPPLY_LOW,
	input  wire logic       I_SUPPLY_OVER,
	// Interrupt
	output var  logic       O_IRQ_OUT_N
);

	pebank_state_s state_reg;
	pebank_state_s state_next;

	logic                       ms_tick;
	logic                       btn_pressed;
	logic [4:0]                 hold_reached;
	logic [PEB_GROUPS-1:0][7:0] set_ev;
	logic [PEB_GROUPS-1:0][7:0] clr_ev;
	logic [7:0]                 category;
	logic [7:0]                 rd_mux;
	logic                       pending;

	// ------------------------------------------------------------
	// Timing and button
	// ------------------------------------------------------------
	assign ms_tick     = (state_reg.ms_div == PEB_DIV_W'(MS_CYCLES - 1));
	assign btn_pressed = ~I_POWER_BUTTON_N;

	// Thresholds compared against whole milliseconds of debounced hold
	assign hold_reached = {state_reg.hold_ms >= PEB_HOLD8_MS,
		state_reg.hold_ms >= PEB_HOLD4_MS,
		state_reg.hold_ms >= PEB_HOLD3_MS,
		state_reg.hold_ms >= PEB_HOLD2_MS,
		state_reg.hold_ms >= PEB_HOLD1_MS};

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		set_ev     = '0;
		clr_ev     = '0;

		// Millisecond prescaler for debounce and hold timing
		if (ms_tick) begin
			state_next.ms_div = '0;
		end else begin
			state_next.ms_div = state_reg.ms_div + PEB_DIV_W'(1);
		end

		// Debounce: the level must differ for the programmed time
		if (btn_pressed != state_reg.btn_live) begin
			if (state_reg.deb_cnt >= (state_reg.btn_live ? I_DEB_RELEASE_MS
					: I_DEB_PRESS_MS)) begin
				state_next.btn_live = btn_pressed;
				state_next.deb_cnt  = '0;
				set_ev[PEB_G_BTN][0] = 1'b1;
			end else if (ms_tick && state_reg.deb_cnt != 8'hFF) begin
				state_next.deb_cnt = state_reg.deb_cnt + 8'h01;
			end
		end else begin
			state_next.deb_cnt = '0;
		end

		// Hold timer runs only while the debounced press stands
		if (!state_reg.btn_live) begin
			state_next.hold_ms   = '0;
			state_next.hold_live = '0;
		end else begin
			if (ms_tick && state_reg.hold_ms != PEB_HOLD8_MS) begin
				state_next.hold_ms = state_reg.hold_ms + PEB_HOLD_W'(1);
			end
			state_next.hold_live = hold_reached;
			set_ev[PEB_G_BTN][5:1] = hold_reached & ~state_reg.hold_live;
		end

		// Regulator faults set their flags while present
		set_ev[PEB_G_REG][2:0] = I_REG_FAULT;

		// Temperature thresholds: any crossing, either direction
		state_next.temp_prev = {I_TEMP_HIGH_ABOVE, I_TEMP_LOW_ABOVE};
		set_ev[PEB_G_TEMP][PEB_TEMP_LOW]  =
			I_TEMP_LOW_ABOVE ^ state_reg.temp_prev[0];
		set_ev[PEB_G_TEMP][PEB_TEMP_HIGH] =
			I_TEMP_HIGH_ABOVE ^ state_reg.temp_prev[1];

		// Miscellaneous events
		state_next.supply_prev = {I_SUPPLY_OVER, I_SUPPLY_LOW};
		set_ev[PEB_G_MISC][PEB_MISC_WAKE] = I_WAKE_DONE;
		set_ev[PEB_G_MISC][PEB_MISC_DOZE] = I_DOZE_DONE;
		set_ev[PEB_G_MISC][PEB_MISC_PBTN] = I_POWER_BUTTON_EVT;
		set_ev[PEB_G_MISC][PEB_MISC_LOW]  =
			I_SUPPLY_LOW ^ state_reg.supply_prev[0];
		set_ev[PEB_G_MISC][PEB_MISC_OVER] =
			I_SUPPLY_OVER ^ state_reg.supply_prev[1];

		// Register writes: status is write-one-to-clear, mask is plain
		for (int g = 0; g < PEB_GROUPS; g++) begin
			if (I_REG_WR && I_REG_ADDR == PEB_STAT_ADDR[g]) begin
				clr_ev[g] = I_REG_WDATA;
			end
			if (I_REG_WR && I_REG_ADDR == PEB_MASK_ADDR[g]) begin
				state_next.mask[g] = I_REG_WDATA & PEB_VALID_BITS[g];
			end
			// A set in the clearing cycle wins, so no event is lost
			state_next.stat[g] = ((state_reg.stat[g] & ~clr_ev[g]) | set_ev[g])
				& PEB_VALID_BITS[g];
		end

		// Irq follows the next flags so it lines up with status reads
		pending = 1'b0;
		for (int g = 0; g < PEB_GROUPS; g++) begin
			pending = pending | (|(state_next.stat[g] & ~state_next.mask[g]));
		end
		state_next.irq_n = ~pending;

		// Read data is registered and stands one cycle behind the strobe
		state_next.rvalid = I_REG_RD;
		if (I_REG_RD) begin
			state_next.rdata = rd_mux;
		end
	end

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	always_comb begin
		category = '0;
		category[PEB_CAT_REG]  = |state_reg.stat[PEB_G_REG];
		category[PEB_CAT_BTN]  = |state_reg.stat[PEB_G_BTN];
		category[PEB_CAT_TEMP] = |state_reg.stat[PEB_G_TEMP];
		category[PEB_CAT_MISC] = |state_reg.stat[PEB_G_MISC];
		unique case (I_REG_ADDR)
			PEB_ADDR_CATEGORY:   rd_mux = category;
			PEB_ADDR_REG_STAT:   rd_mux = state_reg.stat[PEB_G_REG];
			PEB_ADDR_REG_MASK:   rd_mux = state_reg.mask[PEB_G_REG];
			PEB_ADDR_REG_SENSE:  rd_mux = {5'h00, I_REG_FAULT};
			PEB_ADDR_TEMP_STAT:  rd_mux = state_reg.stat[PEB_G_TEMP];
			PEB_ADDR_TEMP_MASK:  rd_mux = state_reg.mask[PEB_G_TEMP];
			PEB_ADDR_TEMP_SENSE: rd_mux = {5'h00, state_reg.temp_prev[1], 1'b0,
				state_reg.temp_prev[0]};
			PEB_ADDR_BTN_STAT:   rd_mux = state_reg.stat[PEB_G_BTN];
			PEB_ADDR_BTN_MASK:   rd_mux = state_reg.mask[PEB_G_BTN];
			PEB_ADDR_BTN_SENSE:  rd_mux = {2'h0, state_reg.hold_live,
				state_reg.btn_live};
			PEB_ADDR_MISC_STAT:  rd_mux = state_reg.stat[PEB_G_MISC];
			PEB_ADDR_MISC_MASK:  rd_mux = state_reg.mask[PEB_G_MISC];
			default:             rd_mux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			state_reg             <= '0;
			for (int g = 0; g < PEB_GROUPS; g++) begin
				state_reg.stat[g] <= PEB_STAT_RESET;
				state_reg.mask[g] <= PEB_VALID_BITS[g];
			end
			state_reg.irq_n       <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign O_REG_RDATA  = state_reg.rdata;
	assign O_REG_RVALID = state_reg.rvalid;
	assign O_IRQ_OUT_N  = state_reg.irq_n;

endmodule : pebank_top

`default_nettype wire

// >>> pebank_monitor.sv
/* Port checker of the event bank: read answers, flags, sense, irq.
   Assumes it is bound to pebank_top and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module pebank_monitor
	import pebank_pkg::*;
(
	// Watched ports
	input wire logic       I_CLK,
	input wire logic       I_RST_N,
	input wire logic       I_REG_WR,
	input wire logic       I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [7:0] O_REG_RDATA,
	input wire logic       O_REG_RVALID,
	input wire logic [2:0] I_REG_FAULT,
	input wire logic       I_TEMP_LOW_ABOVE,
	input wire logic       I_TEMP_HIGH_ABOVE,
	input wire logic       I_WAKE_DONE,
	input wire logic       I_DOZE_DONE,
	input wire logic       I_POWER_BUTTON_EVT,
	input wire logic       O_IRQ_OUT_N
);
	logic       mask_wr_reg;
	logic [1:0] temp_in;
	logic [2:0] misc_in;
	assign temp_in = {I_TEMP_HIGH_ABOVE, I_TEMP_LOW_ABOVE};
	assign misc_in = {I_POWER_BUTTON_EVT, I_DOZE_DONE, I_WAKE_DONE};
	// Any mask write may unmask, so irq is only judged before the first one
	always_ff @(posedge I_CLK)
		mask_wr_reg <= I_RST_N && (mask_wr_reg || (I_REG_WR && I_REG_ADDR[2:0] != 3'h0
			&& I_REG_ADDR inside {8'h19, 8'h21, 8'h25, 8'h29}));
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	a_read_answers: assert property (I_REG_RD |=> O_REG_RVALID)
		else $error("read not answered");
	a_no_stray_valid: assert property (!I_REG_RD |=> !O_REG_RVALID)
		else $error("valid without read");
	a_unused_zero: assert property (
		I_REG_RD && I_REG_ADDR == 8'h18 |=> O_REG_RDATA[7:3] == 5'h0)
		else $error("unused bits not zero");
	a_fault_sense_live: assert property (
		I_REG_RD && I_REG_ADDR == 8'h1A && $stable(I_REG_FAULT)
		|=> O_REG_RDATA == {5'h0, $past(I_REG_FAULT)})
		else $error("fault sense wrong");
	a_temp_sense_level: assert property (
		I_REG_RD && I_REG_ADDR == 8'h22 && $stable(temp_in) && temp_in == $past(temp_in, 2)
		|=> O_REG_RDATA == {5'h0, $past(I_TEMP_HIGH_ABOVE), 1'b0, $past(I_TEMP_LOW_ABOVE)})
		else $error("temperature sense wrong");
	a_fault_flag_set: assert property (
		I_REG_RD && I_REG_ADDR == 8'h18 && $past(I_RST_N)
		|=> (O_REG_RDATA[2:0] & $past(I_REG_FAULT, 2)) == $past(I_REG_FAULT, 2))
		else $error("fault flag missing");
	a_misc_flag_set: assert property (
		I_REG_RD && I_REG_ADDR == 8'h28 && $past(I_RST_N)
		|=> (O_REG_RDATA[2:0] & $past(misc_in, 2)) == $past(misc_in, 2))
		else $error("misc flag missing");
	a_reset_quiet: assert property (
		!$past(I_RST_N) |-> O_IRQ_OUT_N && !O_REG_RVALID && O_REG_RDATA == 8'h00)
		else $error("outputs not idle after reset");
	a_masked_quiet: assert property (!mask_wr_reg |-> O_IRQ_OUT_N)
		else $error("irq while all masked");
endmodule : pebank_monitor
`default_nettype wire

// >>> pebank_host.sv
/* Host model of the register port: strobed writes and reads.
   Assumes a one-cycle valid answer after the read edge. */
`timescale 1ns/100ps
`default_nettype none
module pebank_host (
	// Port to the bank
	input  wire logic       i_clk,
	input  wire logic       i_rvalid,
	input  wire logic [7:0] i_rdata,
	output var  logic       o_wr,
	output var  logic       o_rd,
	output var  logic [7:0] o_addr,
	output var  logic [7:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// Released lines carry the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_wr = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		o_wr = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_rd = 1'b1;
		o_addr = a;
		@(negedge i_clk);
		o_rd = 1'b0;
		o_addr = ~a;
		d = i_rvalid ? i_rdata : 8'hxx;
	endtask : rd
endmodule : pebank_host
`default_nettype wire

// >>> tb.sv
/* Self-checking bench of the event bank with host model and checker.
   Assumes the ms tick shortened to four cycles. */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import pebank_pkg::*;
	localparam int MS = 4;
	logic       clk = 1'b0, rst_n = 1'b0, wr, rd, rvalid, irq_n;
	logic       t_lo = 1'b0, t_hi = 1'b0, btn_n = 1'b1, wake = 1'b0, doze = 1'b0;
	logic       pbtn = 1'b0, s_lo = 1'b0, s_ov = 1'b0;
	logic [2:0] fault = 3'h0;
	logic [7:0] addr, wdata, rdata, d, r, deb = 8'h02, deb_rel = 8'h05;
	int         failures = 0, n_checks = 0, seed = 32'hf8a1_6ba8;
	always #2.5 clk = ~clk;
	pebank_top #(.MS_CYCLES(MS)) dut (.I_CLK(clk), .I_RST_N(rst_n), .I_REG_WR(wr),
		.I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
		.O_REG_RVALID(rvalid), .I_REG_FAULT(fault), .I_TEMP_LOW_ABOVE(t_lo),
		.I_TEMP_HIGH_ABOVE(t_hi), .I_POWER_BUTTON_N(btn_n), .I_DEB_PRESS_MS(deb),
		.I_DEB_RELEASE_MS(deb_rel), .I_WAKE_DONE(wake), .I_DOZE_DONE(doze),
		.I_POWER_BUTTON_EVT(pbtn), .I_SUPPLY_LOW(s_lo), .I_SUPPLY_OVER(s_ov), .O_IRQ_OUT_N(irq_n));
	pebank_host host (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
		.o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk(d, e);
	endtask : rchk
	function automatic logic [7:0] hold_exp(input int ms);
		hold_exp = {2'h0, ms > 8000, ms > 4000, ms > 3000, ms > 2000, ms > 1000, 1'b1};
	endfunction : hold_exp
	task automatic final_report;
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		rchk(PEB_ADDR_REG_STAT, 8'h00);
		// A fault before any mask write sets its flag but must keep irq high
		fault = 3'h1;
		@(negedge clk);
		fault = 3'h0;
		chk({7'h00, irq_n}, 8'h01);
		for (int g = 0; g < PEB_GROUPS; g++) begin
			rchk(PEB_STAT_ADDR[g], (g == PEB_G_REG) ? 8'h01 : 8'h00);
			rchk(PEB_MASK_ADDR[g], PEB_VALID_BITS[g]);
			host.wr(PEB_STAT_ADDR[g], 8'hFF);
			r = 8'($random(seed));
			host.wr(PEB_MASK_ADDR[g], r);
			rchk(PEB_MASK_ADDR[g], r & PEB_VALID_BITS[g]);
			host.wr(PEB_MASK_ADDR[g], 8'h00);
		end
		host.wr(8'h1A, 8'hFF);
		rchk(8'h40, 8'h00);
		// Pulses last into the read so the checker sees them two edges back
		{wake, doze, pbtn, s_lo, s_ov} = 5'h1F;
		rchk(8'h28, 8'h1F);
		{wake, doze, pbtn} = 3'h0;
		rchk(8'h06, 8'h80);
		chk({7'h00, irq_n}, 8'h00);
		host.wr(8'h28, 8'h01);
		rchk(8'h28, 8'h1E);
		host.wr(8'h28, 8'h00);
		rchk(8'h28, 8'h1E);
		host.wr(8'h28, 8'hFF);
		rchk(8'h28, 8'h00);
		chk({7'h00, irq_n}, 8'h01);
		host.wr(8'h29, 8'h10);
		s_ov = 1'b0;
		rchk(8'h28, 8'h10);
		chk({7'h00, irq_n}, 8'h01);
		host.wr(8'h29, 8'h00);
		chk({7'h00, irq_n}, 8'h00);
		host.wr(8'h28, 8'h10);
		repeat (3) begin
			r = 8'($random(seed));
			fault = r[2:0] | 3'h1;
			rchk(8'h1A, {5'h00, fault});
			rchk(8'h18, {5'h00, fault});
			rchk(8'h06, 8'h10);
			chk({7'h00, irq_n}, 8'h00);
			fault = 3'h0;
			host.wr(8'h18, 8'hFF);
			rchk(8'h18, 8'h00);
			rchk(8'h1A, 8'h00);
		end
		t_lo = 1'b1;
		rchk(8'h22, 8'h01);
		rchk(8'h20, 8'h01);
		host.wr(8'h20, 8'h01);
		t_hi = 1'b1;
		rchk(8'h20, 8'h04);
		rchk(8'h06, 8'h40);
		{t_lo, t_hi} = 2'h0;
		rchk(8'h20, 8'h05);
		rchk(8'h22, 8'h00);
		host.wr(8'h20, 8'hFF);
		// A glitch shorter than the debounce must not count as a press
		btn_n = 1'b0;
		@(negedge clk);
		btn_n = 1'b1;
		repeat (4 * MS) @(negedge clk);
		rchk(8'h24, 8'h00);
		btn_n = 1'b0;
		repeat (2500 * MS) @(negedge clk);
		rchk(8'h26, hold_exp(2500));
		rchk(8'h24, hold_exp(2500));
		rchk(8'h06, 8'h20);
		repeat (5700 * MS) @(negedge clk);
		rchk(8'h26, hold_exp(8200));
		host.wr(8'h24, 8'hFF);
		btn_n = 1'b1;
		// Release debounce is longer than press, so the press still stands
		repeat (3 * MS) @(negedge clk);
		rchk(8'h26, 8'h3F);
		repeat (10 * MS) @(negedge clk);
		rchk(8'h26, 8'h00);
		rchk(8'h24, 8'h01);
		final_report;
	end
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		final_report;
	end
endmodule : tb
bind pebank_top pebank_monitor mon (.I_CLK, .I_RST_N, .I_REG_WR, .I_REG_RD, .I_REG_ADDR,
	.O_REG_RDATA, .O_REG_RVALID, .I_REG_FAULT, .I_TEMP_LOW_ABOVE, .I_TEMP_HIGH_ABOVE,
	.I_WAKE_DONE, .I_DOZE_DONE, .I_POWER_BUTTON_EVT, .O_IRQ_OUT_N);
`default_nettype wire
